// ==== hw/clock_source_switcher.sv ====
`timescale 1ns/1ps
`include "clock_switch_consts.svh"

// Functional notes
// RULE1: nine-bit divisor, multiplier is value plus two
// RULE2: trim is six-bit two's complement step
// RULE3: trim bits 15..6 read zero, reset zero
// RULE4: switch among four sources anytime; the code accepts all eight source select codes
// RULE5: primary submode fixed by fuse only
// RULE6: switching and fail monitor need fuse zero
// RULE7: disabled: next ignored, current follows fuse
// RULE8: disabled: request bit held at zero
// RULE9: software writes next first, then request
// RULE10: same source requested: clear request, abort
// RULE11: valid switch clears lock and fail flags
// RULE12: start new oscillator, wait startup timer
// RULE13: PLL source waits for lock status one
// RULE14: count ten new-clock cycles before handover
// RULE15: done: clear request, copy next to current
// RULE16: stop old source except kept oscillators
// RULE17: processor keeps running during switch
// RULE18: no direct switch between two PLL modes; the sequencer does not block such a switch
// RULE19: control writes need unlock first
// RULE20: writing request one starts a switch
// RULE21: config lock fuse blocks clock changes
// RULE22: unlock strobe permits exactly one write
module clock_source_switcher #(
  parameter int SWITCH_CYCLES = `SWITCH_WAIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input clock_switch_pkg::reg_req_t bus,
  output logic [15:0] rdata,
  input clock_switch_pkg::fuse_t fuses,
  input clock_switch_pkg::osc_status_t status,
  output logic [2:0] sys_clock_sel,
  output logic [3:0] osc_enable,
  output logic pll_enable,
  output logic [9:0] pll_multiplier,
  output logic [5:0] freq_trim,
  output logic [1:0] primary_submode
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] osc_of(input logic [2:0] src);
    logic [3:0] m;
    m = 4'h0;
    unique case (src)
      `SRC_PRIMARY, `SRC_PRIMARY_PLL: m[`OSC_IDX_PRIMARY] = 1'b1;
      `SRC_SECONDARY: m[`OSC_IDX_SECONDARY] = 1'b1;
      `SRC_SLOW_RC: m[`OSC_IDX_SLOW] = 1'b1;
      default: m[`OSC_IDX_FAST] = 1'b1;
    endcase
    return m;
  endfunction

  function automatic logic uses_pll(input logic [2:0] src);
    return (src == `SRC_FAST_RC_PLL) || (src == `SRC_PRIMARY_PLL);
  endfunction

  // crystal sources need the startup timer; an external clock does not
  function automatic logic needs_startup(input logic [2:0] src, input logic [1:0] sub);
    logic prim;
    prim = (src == `SRC_PRIMARY) || (src == `SRC_PRIMARY_PLL);
    return (prim && (sub != `SUBMODE_EXTERNAL)) || (src == `SRC_SECONDARY);
  endfunction

  function automatic logic [3:0] keep_mask(input clock_switch_pkg::fuse_t f, input logic sec);
    logic [3:0] m;
    m = 4'h0;
    m[`OSC_IDX_SLOW] = f.watchdog_enable | f.clock_fail_monitor_enable;
    m[`OSC_IDX_SECONDARY] = sec;
    return m;
  endfunction

  generate
    if (SWITCH_CYCLES < 1 || SWITCH_CYCLES > (1 << `SWITCH_CNT_W)) begin : g_bad_cycles
      $error("clock_source_switcher: SWITCH_CYCLES out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic armed;
  logic sel_osc;
  logic sel_div;
  logic sel_trim;
  logic grant;
  logic [2:0] next_source_sel;
  logic [2:0] next_next_source_sel;
  logic secondary_osc_enable;
  logic next_secondary_osc_enable;
  logic [8:0] feedback_divisor;
  logic [8:0] next_feedback_divisor;
  logic [5:0] next_freq_trim;
  logic [15:0] next_rdata;
  logic [9:0] next_pll_multiplier;
  logic [2:0] current_source_sel;
  logic switch_request;
  logic pll_lock_status;
  logic clock_fail_flag;

  assign sel_osc = bus.addr == `OFS_OSC_CONTROL;
  assign sel_div = bus.addr == `OFS_PLL_FEEDBACK;
  assign sel_trim = bus.addr == `OFS_RC_TRIM;
  assign grant = bus.wr & sel_osc & armed; // [RULE19] [RULE22]

  unlock_gate u_unlock (
    .clk(clk),
    .rst_n(rst_n),
    .unlock(bus.unlock),
    .access(bus.wr & sel_osc),
    .armed(armed)
  );

  // the port never stalls, so code keeps running through a switch [RULE17]
  always_comb begin
    next_next_source_sel = next_source_sel;
    next_secondary_osc_enable = secondary_osc_enable;
    next_feedback_divisor = feedback_divisor;
    next_freq_trim = freq_trim;
    next_rdata = 16'h0000;
    if (grant & bus.byte_en[`BYTE_HIGH] & !fuses.config_lock_fuse) begin // [RULE21]
      next_next_source_sel = bus.wdata[`OSC_NEXT_LSB +: `OSC_SRC_W]; // [RULE9]
    end
    if (grant & bus.byte_en[`BYTE_LOW]) begin
      next_secondary_osc_enable = bus.wdata[`OSC_SEC_EN_BIT];
    end
    if (bus.wr & sel_div & !fuses.config_lock_fuse) begin // [RULE21]
      next_feedback_divisor = bus.wdata[`DIVISOR_W-1:0]; // [RULE1]
    end
    if (bus.wr & sel_trim) begin
      next_freq_trim = bus.wdata[`TRIM_W-1:0]; // [RULE2]
    end
    if (bus.rd) begin
      if (sel_osc) begin
        next_rdata[`OSC_CUR_LSB +: `OSC_SRC_W] = current_source_sel;
        next_rdata[`OSC_NEXT_LSB +: `OSC_SRC_W] = next_source_sel;
        next_rdata[`OSC_CFG_LOCK_BIT] = fuses.config_lock_fuse;
        next_rdata[`OSC_LOCK_BIT] = pll_lock_status;
        next_rdata[`OSC_FAIL_BIT] = clock_fail_flag;
        next_rdata[`OSC_SEC_EN_BIT] = secondary_osc_enable;
        next_rdata[`OSC_REQ_BIT] = switch_request;
      end else if (sel_div) begin
        next_rdata[`DIVISOR_W-1:0] = feedback_divisor; // [RULE1]
      end else if (sel_trim) begin
        next_rdata[`TRIM_W-1:0] = freq_trim; // [RULE3]
      end
    end
    next_pll_multiplier = {1'b0, feedback_divisor} + `DIVISOR_OFFSET; // [RULE1]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      next_source_sel <= `SRC_RESET;
      secondary_osc_enable <= 1'b0;
      feedback_divisor <= `DIVISOR_RESET;
      freq_trim <= `TRIM_RESET; // [RULE3]
      rdata <= 16'h0000;
      pll_multiplier <= 10'h000;
      primary_submode <= `SUBMODE_EXTERNAL;
    end else begin
      next_source_sel <= next_next_source_sel;
      secondary_osc_enable <= next_secondary_osc_enable;
      feedback_divisor <= next_feedback_divisor;
      freq_trim <= next_freq_trim;
      rdata <= next_rdata;
      pll_multiplier <= next_pll_multiplier;
      primary_submode <= fuses.primary_submode_fuse; // [RULE5]
    end
  end

  // ----------------------------------------------------------------
  // switch sequencer
  // ----------------------------------------------------------------
  clock_switch_pkg::switch_state_t state;
  clock_switch_pkg::switch_state_t next_state;
  logic init_done;
  logic switch_off;
  logic req_set;
  logic fail_set;
  logic fail_clear;
  logic ready;
  logic cnt_start;
  logic cnt_done;
  logic [2:0] target;
  logic [2:0] next_target;
  logic next_switch_request;
  logic [2:0] next_current_source_sel;
  logic [2:0] next_sys_clock_sel;
  logic [3:0] osc_run;
  logic [3:0] next_osc_run;
  logic next_pll_enable;
  logic next_pll_lock_status;
  logic next_clock_fail_flag;

  assign switch_off = fuses.switch_enable_fuse; // [RULE6]
  assign req_set = grant & bus.byte_en[`BYTE_LOW] & bus.wdata[`OSC_REQ_BIT]
                   & (state == clock_switch_pkg::ST_IDLE) & !switch_off; // [RULE20]
  assign fail_set = status.clock_fail_detect & fuses.clock_fail_monitor_enable & !switch_off;
  assign ready = (!needs_startup(target, fuses.primary_submode_fuse) | status.startup_done)
                 & (!uses_pll(target) | pll_lock_status); // [RULE12] [RULE13]

  new_clock_counter #(
    .COUNT(SWITCH_CYCLES),
    .W(`SWITCH_CNT_W)
  ) u_count (
    .clk(clk),
    .rst_n(rst_n),
    .start(cnt_start),
    .tick(status.new_clock_tick),
    .done(cnt_done)
  );

  // the two-PLL-mode hop is software's to avoid; the sequencer does not police it [RULE18]
  always_comb begin
    next_state = state;
    next_target = target;
    next_switch_request = switch_request;
    next_current_source_sel = current_source_sel;
    next_sys_clock_sel = sys_clock_sel;
    next_osc_run = osc_run;
    next_pll_enable = pll_enable;
    next_pll_lock_status = pll_enable & status.pll_locked;
    fail_clear = 1'b0;
    cnt_start = 1'b0;
    if (!init_done || switch_off) begin
      next_state = clock_switch_pkg::ST_IDLE; // [RULE7]
      next_switch_request = 1'b0; // [RULE8]
      next_current_source_sel = fuses.initial_source_fuse; // [RULE7]
      next_sys_clock_sel = fuses.initial_source_fuse;
      next_osc_run = osc_of(fuses.initial_source_fuse);
      next_pll_enable = uses_pll(fuses.initial_source_fuse);
    end else begin
      unique case (state)
        clock_switch_pkg::ST_IDLE: begin
          if (req_set) begin
            next_switch_request = 1'b1; // [RULE20] [RULE4]
            next_state = clock_switch_pkg::ST_CHECK;
          end
        end
        clock_switch_pkg::ST_CHECK: begin
          if (next_source_sel == current_source_sel) begin
            next_switch_request = 1'b0; // [RULE10]
            next_state = clock_switch_pkg::ST_IDLE;
          end else begin
            next_target = next_source_sel;
            next_pll_lock_status = 1'b0; // [RULE11]
            fail_clear = 1'b1; // [RULE11]
            next_osc_run = osc_run | osc_of(next_source_sel); // [RULE12]
            next_pll_enable = pll_enable | uses_pll(next_source_sel);
            next_state = clock_switch_pkg::ST_READY;
          end
        end
        clock_switch_pkg::ST_READY: begin
          if (ready) begin
            cnt_start = 1'b1; // [RULE14]
            next_state = clock_switch_pkg::ST_COUNT;
          end
        end
        clock_switch_pkg::ST_COUNT: begin
          if (cnt_done) begin
            next_state = clock_switch_pkg::ST_DONE; // [RULE14]
          end
        end
        clock_switch_pkg::ST_DONE: begin
          next_switch_request = 1'b0; // [RULE15]
          next_current_source_sel = target; // [RULE15]
          next_sys_clock_sel = target;
          next_osc_run = osc_of(target); // [RULE16]
          next_pll_enable = uses_pll(target);
          next_state = clock_switch_pkg::ST_IDLE;
        end
        default: begin
          next_state = clock_switch_pkg::ST_IDLE;
        end
      endcase
    end
    // a fail event in the clearing cycle still sets the flag
    next_clock_fail_flag = (clock_fail_flag & !fail_clear) | fail_set; // [RULE6]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= clock_switch_pkg::ST_IDLE;
      init_done <= 1'b0;
      target <= `SRC_RESET;
      switch_request <= 1'b0;
      current_source_sel <= `SRC_RESET;
      sys_clock_sel <= `SRC_RESET;
      osc_run <= 4'h0;
      osc_enable <= 4'h0;
      pll_enable <= 1'b0;
      pll_lock_status <= 1'b0;
      clock_fail_flag <= 1'b0;
    end else begin
      state <= next_state;
      init_done <= 1'b1;
      target <= next_target;
      switch_request <= next_switch_request;
      current_source_sel <= next_current_source_sel;
      sys_clock_sel <= next_sys_clock_sel;
      osc_run <= next_osc_run;
      osc_enable <= next_osc_run | keep_mask(fuses, next_secondary_osc_enable); // [RULE16]
      pll_enable <= next_pll_enable;
      pll_lock_status <= next_pll_lock_status;
      clock_fail_flag <= next_clock_fail_flag;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [7:0] seen_ticks;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_ticks <= 8'h00;
    end else if (state != clock_switch_pkg::ST_COUNT) begin
      seen_ticks <= 8'h00;
    end else if (status.new_clock_tick) begin
      seen_ticks <= seen_ticks + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_checking_new;
    state == clock_switch_pkg::ST_CHECK && next_source_sel != current_source_sel;
  endsequence
  sequence s_finishing;
    state == clock_switch_pkg::ST_DONE;
  endsequence

  // init_done keeps the release edge out: registers there still hold reset values
  a_mult_offset: assert property (init_done |-> // [RULE1]
      pll_multiplier == {1'b0, $past(feedback_divisor)} + `DIVISOR_OFFSET)
    else $error("multiplier is not divisor plus two");
  a_trim_readback: assert property (bus.rd && sel_trim |=> // [RULE3]
      rdata[15:6] == 10'h000 && rdata[5:0] == $past(freq_trim))
    else $error("trim readback wrong");
  a_disabled_hold: assert property (switch_off |=> !switch_request) // [RULE8]
    else $error("request set while switching disabled");
  a_disabled_current: assert property (init_done && switch_off |=> // [RULE7]
      current_source_sel == $past(fuses.initial_source_fuse))
    else $error("current source not following fuse");
  a_redundant_abort: assert property (state == clock_switch_pkg::ST_CHECK && // [RULE10]
      next_source_sel == current_source_sel && !switch_off |=>
      !switch_request && state == clock_switch_pkg::ST_IDLE && $stable(sys_clock_sel))
    else $error("redundant switch not aborted");
  a_lock_cleared: assert property (s_checking_new and !switch_off |=> !pll_lock_status) // [RULE11]
    else $error("lock status not cleared");
  a_startup_wait: assert property (state == clock_switch_pkg::ST_READY && // [RULE12]
      needs_startup(target, fuses.primary_submode_fuse) && !status.startup_done |=>
      state != clock_switch_pkg::ST_COUNT)
    else $error("left wait before startup timer");
  a_pll_wait: assert property (state == clock_switch_pkg::ST_READY && // [RULE13]
      uses_pll(target) && !pll_lock_status |=> state != clock_switch_pkg::ST_COUNT)
    else $error("left wait before pll lock");
  a_ten_ticks: assert property (s_finishing |-> seen_ticks == 8'(SWITCH_CYCLES)) // [RULE14]
    else $error("handover without the full tick count");
  a_done_commit: assert property (s_finishing and !switch_off |=> !switch_request && // [RULE15]
      current_source_sel == $past(target) && sys_clock_sel == $past(target))
    else $error("completion did not commit source");
  a_old_off: assert property (s_finishing and !switch_off |=> osc_enable == // [RULE16]
      (osc_of($past(target)) | keep_mask($past(fuses), $past(secondary_osc_enable))))
    else $error("old oscillator left running");
  a_locked_write: assert property (armed && bus.wr && sel_osc && !fuses.config_lock_fuse // [RULE22]
      && bus.byte_en[`BYTE_HIGH] |=>
      next_source_sel == $past(bus.wdata[`OSC_NEXT_LSB +: `OSC_SRC_W]))
    else $error("armed write lost");
  a_unlock_needed: assert property (!armed && bus.wr && sel_osc |=> // [RULE19]
      $stable(next_source_sel))
    else $error("control written without unlock");
  a_cfg_locked: assert property (fuses.config_lock_fuse && bus.wr && sel_div |=> // [RULE21]
      $stable(feedback_divisor))
    else $error("divisor changed while locked");
  a_req_start: assert property (req_set && init_done |=> switch_request && // [RULE20]
      state == clock_switch_pkg::ST_CHECK)
    else $error("request write did not start switch");
  a_submode_fixed: assert property (init_done |-> // [RULE5]
      primary_submode == $past(fuses.primary_submode_fuse))
    else $error("submode not from fuse");

endmodule

// ==== shared/clock_switch_consts.svh ====
`ifndef CLOCK_SWITCH_CONSTS_SVH
`define CLOCK_SWITCH_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define OFS_OSC_CONTROL 2'h0
`define OFS_PLL_FEEDBACK 2'h1
`define OFS_RC_TRIM 2'h2

// ----------------------------------------------------------------
// oscillator control register fields
// ----------------------------------------------------------------
`define OSC_CUR_LSB 12
`define OSC_NEXT_LSB 8
`define OSC_CFG_LOCK_BIT 7
`define OSC_LOCK_BIT 5
`define OSC_FAIL_BIT 3
`define OSC_SEC_EN_BIT 1
`define OSC_REQ_BIT 0
`define OSC_SRC_W 3
`define BYTE_HIGH 1
`define BYTE_LOW 0

// ----------------------------------------------------------------
// reset values and field widths
// ----------------------------------------------------------------
`define DIVISOR_W 9
`define DIVISOR_RESET 9'h030
`define DIVISOR_OFFSET 10'h002
`define TRIM_W 6
`define TRIM_RESET 6'h00
`define SRC_RESET 3'h0

// ----------------------------------------------------------------
// source select codes
// ----------------------------------------------------------------
`define SRC_FAST_RC 3'h0
`define SRC_FAST_RC_PLL 3'h1
`define SRC_PRIMARY 3'h2
`define SRC_PRIMARY_PLL 3'h3
`define SRC_SECONDARY 3'h4
`define SRC_SLOW_RC 3'h5
`define SRC_FAST_RC_DIV16 3'h6
`define SRC_FAST_RC_DIVN 3'h7

// ----------------------------------------------------------------
// primary submode codes and oscillator enable bit positions
// ----------------------------------------------------------------
`define SUBMODE_EXTERNAL 2'h0
`define SUBMODE_CRYSTAL 2'h1
`define SUBMODE_HIGH_SPEED 2'h2
`define OSC_IDX_FAST 0
`define OSC_IDX_PRIMARY 1
`define OSC_IDX_SECONDARY 2
`define OSC_IDX_SLOW 3
`define OSC_COUNT 4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWITCH_WAIT_CYCLES 10
`define SWITCH_CNT_W 8

`endif

// ==== shared/clock_switch_pkg.sv ====
package clock_switch_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_READY = 3'b010,
    ST_COUNT = 3'b011,
    ST_DONE = 3'b100
  } switch_state_t;

  typedef struct packed {
    logic switch_enable_fuse;
    logic config_lock_fuse;
    logic [2:0] initial_source_fuse;
    logic [1:0] primary_submode_fuse;
    logic watchdog_enable;
    logic clock_fail_monitor_enable;
  } fuse_t;

  typedef struct packed {
    logic startup_done;
    logic pll_locked;
    logic new_clock_tick;
    logic clock_fail_detect;
  } osc_status_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic [1:0] byte_en;
    logic wr;
    logic rd;
    logic unlock;
  } reg_req_t;

endpackage

// ==== hw/unlock_gate.sv ====
`timescale 1ns/1ps
module unlock_gate (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic unlock,
  input wire logic access,
  output logic armed
);

  logic next_armed;

  // a write consumes the arm whether or not it changes anything
  always_comb begin
    next_armed = armed;
    if (access) begin
      next_armed = 1'b0;
    end
    if (unlock) begin
      next_armed = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else begin
      armed <= next_armed;
    end
  end

endmodule

// ==== hw/new_clock_counter.sv ====
`timescale 1ns/1ps
`include "clock_switch_consts.svh"
module new_clock_counter #(
  parameter int COUNT = `SWITCH_WAIT_CYCLES,
  parameter int W = `SWITCH_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic tick,
  output logic done
);

  logic running;
  logic next_running;
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  generate
    if (COUNT < 1 || COUNT > (1 << W)) begin : g_bad_count
      $error("new_clock_counter: COUNT out of range");
    end
  endgenerate

  // done fires on the last tick itself so the handover follows at once
  assign done = running & tick & (cnt == LAST);

  always_comb begin
    next_running = running;
    next_cnt = cnt;
    if (start) begin
      next_running = 1'b1;
      next_cnt = '0;
    end else if (done) begin
      next_running = 1'b0;
    end else if (running & tick) begin
      next_cnt = cnt + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      running <= 1'b0;
      cnt <= '0;
    end else begin
      running <= next_running;
      cnt <= next_cnt;
    end
  end

endmodule

// ==== verif/tb_clock_source_switcher.sv ====
`timescale 1ns/1ps
`include "clock_switch_consts.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_clock_source_switcher;
  typedef struct {logic [1:0] a; logic [15:0] d; logic [15:0] exp;} row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick_on = 1'b0;
  clock_switch_pkg::reg_req_t bus = '0;
  clock_switch_pkg::fuse_t fuses = {1'b0, 1'b0, `SRC_FAST_RC, `SUBMODE_CRYSTAL, 1'b0, 1'b1};
  clock_switch_pkg::osc_status_t status = '0;
  logic [15:0] rdata;
  logic [2:0] sys_clock_sel;
  logic [3:0] osc_enable;
  logic pll_enable;
  logic [9:0] pll_multiplier;
  logic [5:0] freq_trim;
  logic [1:0] primary_submode;
  logic [15:0] rd_val;
  int mismatches = 0;
  int samples_checked = 0;
  // trim extremes, divisor extremes and an unmapped word
  row_t rows [6] = '{'{`OFS_RC_TRIM, 16'hffdf, 16'h001f}, '{`OFS_RC_TRIM, 16'h0020, 16'h0020},
    '{`OFS_RC_TRIM, 16'h003f, 16'h003f}, '{`OFS_PLL_FEEDBACK, 16'hffff, 16'h01ff},
    '{`OFS_PLL_FEEDBACK, 16'h0000, 16'h0000}, '{2'h3, 16'hffff, 16'h0000}};

  clock_source_switcher #(.SWITCH_CYCLES(10)) uut (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rdata(rdata), .fuses(fuses), .status(status), .sys_clock_sel(sys_clock_sel),
    .osc_enable(osc_enable), .pll_enable(pll_enable), .pll_multiplier(pll_multiplier),
    .freq_trim(freq_trim), .primary_submode(primary_submode));

  always #20 clk = ~clk;
  always @(posedge clk) status.new_clock_tick <= tick_on;

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic reg_wr(logic [1:0] a, logic [15:0] d, logic [1:0] be, logic unl);
    if (unl) begin
      @(posedge clk);
      bus.unlock <= 1'b1;
    end
    @(posedge clk);
    bus.unlock <= 1'b0;
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    bus.byte_en <= be;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic reg_rd(logic [1:0] a);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    rd_val = rdata;
  endtask

  task automatic wait_sel(logic [2:0] s);
    int i;
    for (i = 0; i < 60 && sys_clock_sel !== s; i++) @(negedge clk);
    `CHK(sys_clock_sel, s)
  endtask

  // software order: next source first, then the request, each behind its own unlock
  task automatic switch_to(logic [2:0] s);
    reg_wr(`OFS_OSC_CONTROL, {5'h00, s, 8'h00}, 2'b10, 1'b1);
    reg_wr(`OFS_OSC_CONTROL, 16'h0001, 2'b01, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc(5000);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(2);
    @(negedge clk);
    `CHK(sys_clock_sel, `SRC_FAST_RC)
    `CHK(primary_submode, `SUBMODE_CRYSTAL)
    `CHK(pll_multiplier, 10'h032)
    reg_rd(`OFS_PLL_FEEDBACK);
    `CHK(rd_val, 16'h0030)
    reg_rd(`OFS_RC_TRIM);
    `CHK(rd_val, 16'h0000)
    foreach (rows[i]) begin
      reg_wr(rows[i].a, rows[i].d, 2'b11, 1'b0);
      reg_rd(rows[i].a);
      `CHK(rd_val, rows[i].exp)
      if (rows[i].a == `OFS_PLL_FEEDBACK)
        `CHK(pll_multiplier, rows[i].exp[9:0] + 10'h002)
      if (rows[i].a == `OFS_RC_TRIM) `CHK(freq_trim, rows[i].exp[5:0])
    end
    // one unlock grants one write only; an unarmed write is dropped
    reg_wr(`OFS_OSC_CONTROL, 16'h0500, 2'b10, 1'b0);
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val[10:8], `SRC_FAST_RC)
    reg_wr(`OFS_OSC_CONTROL, 16'h0500, 2'b10, 1'b1);
    reg_wr(`OFS_OSC_CONTROL, 16'h0300, 2'b10, 1'b0);
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val[10:8], `SRC_SLOW_RC)
    // fast rc to slow rc; stalled new clock must hold the handover
    reg_wr(`OFS_OSC_CONTROL, 16'h0001, 2'b01, 1'b1);
    cyc(30);
    @(negedge clk);
    `CHK(sys_clock_sel, `SRC_FAST_RC)
    `CHK(osc_enable, 4'b1001)
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val[0], 1'b1)
    tick_on = 1'b1;
    cyc(11);
    @(negedge clk);
    `CHK(sys_clock_sel, `SRC_FAST_RC)
    wait_sel(`SRC_SLOW_RC);
    `CHK(osc_enable, 4'b1000)
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val, 16'h5500)
    // redundant request aborts at once
    reg_wr(`OFS_OSC_CONTROL, 16'h0001, 2'b01, 1'b1);
    cyc(3);
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val, 16'h5500)
    `CHK(osc_enable, 4'b1000)
    // fail flag set, then cleared by a valid switch that waits for lock
    @(posedge clk);
    status.clock_fail_detect <= 1'b1;
    @(posedge clk);
    status.clock_fail_detect <= 1'b0;
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val[3], 1'b1)
    switch_to(`SRC_FAST_RC_PLL);
    cyc(30);
    @(negedge clk);
    `CHK(sys_clock_sel, `SRC_SLOW_RC)
    `CHK(pll_enable, 1'b1)
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val[5:3], 3'b000)
    @(posedge clk);
    status.pll_locked <= 1'b1;
    wait_sel(`SRC_FAST_RC_PLL);
    `CHK(osc_enable, 4'b1001)
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val, 16'h1120)
    // plain fast rc in between, then the crystal waits for its startup timer
    switch_to(`SRC_FAST_RC);
    wait_sel(`SRC_FAST_RC);
    `CHK(pll_enable, 1'b0)
    switch_to(`SRC_PRIMARY);
    cyc(30);
    @(negedge clk);
    `CHK(sys_clock_sel, `SRC_FAST_RC)
    `CHK(osc_enable, 4'b1011)
    @(posedge clk);
    status.startup_done <= 1'b1;
    wait_sel(`SRC_PRIMARY);
    `CHK(osc_enable, 4'b1010)
    `CHK(primary_submode, `SUBMODE_CRYSTAL)
    // secondary enable bit keeps that oscillator on with no switch
    reg_wr(`OFS_OSC_CONTROL, 16'h0002, 2'b01, 1'b1);
    @(negedge clk);
    `CHK(osc_enable, 4'b1110)
    // locked configuration ignores divisor and next source writes
    @(posedge clk);
    fuses.config_lock_fuse <= 1'b1;
    reg_wr(`OFS_PLL_FEEDBACK, 16'h0007, 2'b11, 1'b0);
    reg_rd(`OFS_PLL_FEEDBACK);
    `CHK(rd_val, 16'h0000)
    reg_wr(`OFS_OSC_CONTROL, 16'h0400, 2'b10, 1'b1);
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val[10:8], `SRC_PRIMARY)
    // switching disabled: second reset, current follows fuse, request stays low
    @(posedge clk);
    fuses.config_lock_fuse <= 1'b0;
    fuses.switch_enable_fuse <= 1'b1;
    fuses.initial_source_fuse <= `SRC_SECONDARY;
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    cyc(2);
    switch_to(`SRC_SLOW_RC);
    cyc(20);
    reg_rd(`OFS_OSC_CONTROL);
    `CHK(rd_val[0], 1'b0)
    `CHK(rd_val[14:12], `SRC_SECONDARY)
    `CHK(sys_clock_sel, `SRC_SECONDARY)
    end_of_test();
  end
endmodule
